//--- shared/rl_sel_pkg.sv
// constants shared by the remote/local input selector and its range codec
package rl_sel_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SET    = 8'h04;
  localparam logic [7:0] OFF_FREQ   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK   = 8'h10;
  localparam logic [7:0] OFF_LOCK   = 8'h14;
  // settings word: {fm[2:0], am[1:0], alc[1:0], rf_on, range[4:0]}
  localparam int SET_W   = 13;
  localparam int F_RANGE = 0;
  localparam int F_RF    = 5;
  localparam int F_ALC   = 6;
  localparam int F_AM    = 8;
  localparam int F_FM    = 10;
  localparam logic [12:0] SET_RST = 13'h0000;
  // range code: bit 4 overrange, bits 3:0 attenuation in 10 dB steps
  localparam int         RANGE_W        = 5;
  localparam int         RANGE_OVR_BIT  = 4;
  localparam logic [3:0] POS_FIRST      = 4'h1;
  localparam logic [3:0] POS_ZERO_DB    = 4'hC;
  localparam logic [3:0] POS_OVR        = 4'hD;
  localparam logic [3:0] RANGE_MAX_TENS = 4'hB;
  localparam logic [4:0] RANGE_BAD      = 5'h0F;
  // status / mask bits
  localparam int ST_W     = 6;
  localparam int ST_LOOP  = 0;
  localparam int ST_SUM   = 4;
  localparam int ST_UNLEVEL = 5;
  localparam int NUM_LOOPS = 4;
  localparam int SUM_LOOP  = 3;
  // frequency in kHz
  localparam int unsigned FREQ_MIN_KHZ = 2000000;
  localparam int unsigned FREQ_MAX_KHZ = 18000000;
  localparam int          NUM_RES      = 6;
  localparam int unsigned TUNE_STEP_KHZ [0:5] = '{1, 10, 100, 1000, 10000, 100000};
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} bus_state_t;
endpackage : rl_sel_pkg

//--- rtl/range_codec.sv
// range selector encoder and range data decoder
`timescale 1ns/100ps
`default_nettype none
module range_codec (
  input  wire logic [3:0] sel_pos,     // range selector position 1..13
  input  wire logic [4:0] active_code, // range data in force
  output logic      [4:0] local_code,  // selector position in remote format
  output logic      [3:0] disp_tens,   // display attenuation, 10 dB units
  output logic            disp_ovr,    // display overrange
  output logic            out_of_range // range data not servable
);
  always_comb begin
    if (sel_pos >= rl_sel_pkg::POS_FIRST && sel_pos <= rl_sel_pkg::POS_ZERO_DB) begin
      local_code = {1'b0, 4'(rl_sel_pkg::POS_ZERO_DB - sel_pos)};
    end else if (sel_pos == rl_sel_pkg::POS_OVR) begin
      local_code = {1'b1, 4'h0};
    end else begin
      // a broken selector reads as an illegal code so the panel flags it
      local_code = rl_sel_pkg::RANGE_BAD;
    end
  end

  always_comb begin
    disp_tens = active_code[3:0];
    disp_ovr  = active_code[rl_sel_pkg::RANGE_OVR_BIT];
    if (active_code[rl_sel_pkg::RANGE_OVR_BIT]) begin
      out_of_range = (active_code[3:0] != 4'h0);
    end else begin
      out_of_range = (active_code[3:0] > rl_sel_pkg::RANGE_MAX_TENS);
    end
  end
endmodule : range_codec
`default_nettype wire

//--- rtl/remote_local_input_selector.sv
// remote/local settings selector, latch, tuning register and lock status
// How it works
// - settings from panel locally, bus remotely
// - latch remote settings until programmed again
// - capture panel settings on entering remote
// - encode range selector into remote format
// - decode active range data for display
// - illegal range data lights unleveled indicator
// - indicators follow mode; unleveled follows level sense
// - remote frequency loads first frequency register
// - encoder steps register by chosen resolution
// - one lock indicator per loop
// - reset summing loop if unlocked or slewing
`timescale 1ns/100ps
`default_nettype none
module remote_local_input_selector #(
  parameter int FREQ_W = 25
) (
  input  wire logic              sys_clk,             // 10 MHz clock
  input  wire logic              sys_rst,             // sync reset, high
  input  wire logic              hsel,                // ahb select
  input  wire logic [31:0]       haddr,               // ahb address
  input  wire logic [1:0]        htrans,              // ahb transfer type
  input  wire logic              hwrite,              // ahb write
  input  wire logic [2:0]        hsize,               // ahb size, word only
  input  wire logic [31:0]       hwdata,              // ahb write data
  input  wire logic              hready,              // ahb bus ready
  output logic                   hreadyout,           // ahb slave ready
  output logic                   hresp,               // ahb response
  output logic      [31:0]       hrdata,              // ahb read data
  input  wire logic [3:0]        panel_range_pos,     // range selector
  input  wire logic              panel_rf_on,         // rf on switch
  input  wire logic [1:0]        panel_alc,           // alc selector
  input  wire logic [1:0]        panel_am,            // am switch
  input  wire logic [2:0]        panel_fm,            // fm deviation switch
  input  wire logic              enc_step,            // rotary_tuning_encoder pulse
  input  wire logic              enc_dir,             // 1 up, 0 down
  input  wire logic [2:0]        tune_res,            // tuning resolution
  input  wire logic              level_unleveled,     // level sensing
  input  wire logic [3:0]        pll_locked,          // loop lock levels
  input  wire logic              slew_excess,         // oscillator slewing
  output logic      [4:0]        range_code,          // attenuator drive
  output logic      [3:0]        range_disp_tens,     // range_indicator_display
  output logic                   range_disp_ovr,      // display overrange
  output logic                   rf_on_led,           // rf status
  output logic      [1:0]        alc_led,             // alc status
  output logic      [1:0]        am_led,              // am status
  output logic      [2:0]        fm_led,              // fm status
  output logic                   unleveled_indicator, // unleveled lamp
  output logic      [3:0]        loop_unlock,         // per-loop unlock lamp
  output logic                   sum_loop_reset,      // summing loop reset
  output logic      [FREQ_W-1:0] freq_reg1,           // first frequency reg
  output logic                   freq_load,           // freq_reg1 loaded or stepped
  output logic                   remote_led,          // remote mode
  output logic                   irq                  // interrupt level
);
  // refuse widths that cannot hold the top of the band
  if (FREQ_W > 32 || (64'd1 << FREQ_W) <= 64'(rl_sel_pkg::FREQ_MAX_KHZ)) begin : g_width_check
    $error("FREQ_W cannot hold the frequency span");
  end

  // bus slave
  rl_sel_pkg::bus_state_t bus_state;
  rl_sel_pkg::bus_state_t next_bus_state;
  logic [7:0]  addr;
  logic [7:0]  next_addr;
  logic [31:0] next_hrdata;
  logic        take;
  logic        wr_go;
  logic        rd_go;
  logic        unused_bus;

  // settings
  logic                        remote_mode;
  logic                        next_remote_mode;
  logic [rl_sel_pkg::SET_W-1:0] remote_set;
  logic [rl_sel_pkg::SET_W-1:0] next_remote_set;
  logic [rl_sel_pkg::SET_W-1:0] live_set;
  logic [rl_sel_pkg::SET_W-1:0] active_set;
  logic [4:0]                  local_code;
  logic [3:0]                  dec_tens;
  logic                        dec_ovr;
  logic                        dec_bad;

  // status
  logic [rl_sel_pkg::ST_W-1:0] status;
  logic [rl_sel_pkg::ST_W-1:0] next_status;
  logic [rl_sel_pkg::ST_W-1:0] mask;
  logic [rl_sel_pkg::ST_W-1:0] next_mask;
  logic [rl_sel_pkg::ST_W-1:0] st_set;
  logic                        unlev_now;
  logic                        sum_now;

  // frequency
  logic [FREQ_W-1:0] next_freq;
  logic              next_load;
  logic [31:0]       step;
  logic [31:0]       f32;

  assign unused_bus = ^{hsize, haddr[31:8]};

  always_comb begin
    take           = hsel && hready && htrans[1];
    wr_go          = (bus_state == rl_sel_pkg::BUS_WRITE);
    rd_go          = (bus_state == rl_sel_pkg::BUS_READ);
    hreadyout      = !rd_go;
    hresp          = 1'b0;
    next_addr      = take ? haddr[7:0] : addr;
    next_bus_state = rl_sel_pkg::BUS_IDLE;
    if (take) begin
      next_bus_state = hwrite ? rl_sel_pkg::BUS_WRITE : rl_sel_pkg::BUS_READ;
    end
    next_hrdata = hrdata;
    if (rd_go) begin
      case (addr)
        rl_sel_pkg::OFF_CTRL:   next_hrdata = {31'h0000_0000, remote_mode};
        rl_sel_pkg::OFF_SET:    next_hrdata = 32'(remote_set);
        rl_sel_pkg::OFF_FREQ:   next_hrdata = 32'(freq_reg1);
        rl_sel_pkg::OFF_STATUS: next_hrdata = 32'(status);
        rl_sel_pkg::OFF_MASK:   next_hrdata = 32'(mask);
        rl_sel_pkg::OFF_LOCK:   next_hrdata = 32'({active_set, pll_locked});
        default:                next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_state <= rl_sel_pkg::BUS_IDLE;
      addr      <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      bus_state <= next_bus_state;
      addr      <= next_addr;
      hrdata    <= next_hrdata;
    end
  end

  range_codec u_codec (
    .sel_pos      (panel_range_pos),
    .active_code  (active_set[rl_sel_pkg::F_RANGE +: 5]),
    .local_code   (local_code),
    .disp_tens    (dec_tens),
    .disp_ovr     (dec_ovr),
    .out_of_range (dec_bad)
  );

  always_comb begin
    live_set   = {panel_fm, panel_am, panel_alc, panel_rf_on, local_code};
    active_set = remote_mode ? remote_set : live_set;
    next_remote_mode = remote_mode;
    next_remote_set  = remote_set;
    if (wr_go && addr == rl_sel_pkg::OFF_CTRL) begin
      next_remote_mode = hwdata[0];
      if (hwdata[0] && !remote_mode) begin
        // freeze the panel so the attenuator does not move on entry
        next_remote_set = live_set;
      end
    end
    if (wr_go && addr == rl_sel_pkg::OFF_SET) begin
      next_remote_set = hwdata[rl_sel_pkg::SET_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      remote_mode <= 1'b0;
      remote_set  <= rl_sel_pkg::SET_RST;
    end else begin
      remote_mode <= next_remote_mode;
      remote_set  <= next_remote_set;
    end
  end

  // indicators, one cycle behind the selected settings
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      range_code          <= 5'h00;
      range_disp_tens     <= 4'h0;
      range_disp_ovr      <= 1'b0;
      rf_on_led           <= 1'b0;
      alc_led             <= 2'h0;
      am_led              <= 2'h0;
      fm_led              <= 3'h0;
      unleveled_indicator <= 1'b0;
      loop_unlock         <= 4'h0;
      sum_loop_reset      <= 1'b0;
      remote_led          <= 1'b0;
    end else begin
      range_code          <= active_set[rl_sel_pkg::F_RANGE +: 5];
      range_disp_tens     <= dec_tens;
      range_disp_ovr      <= dec_ovr;
      rf_on_led           <= active_set[rl_sel_pkg::F_RF];
      alc_led             <= active_set[rl_sel_pkg::F_ALC +: 2];
      am_led              <= active_set[rl_sel_pkg::F_AM +: 2];
      fm_led              <= active_set[rl_sel_pkg::F_FM +: 3];
      unleveled_indicator <= unlev_now;
      loop_unlock         <= ~pll_locked;
      sum_loop_reset      <= sum_now;
      remote_led          <= remote_mode;
    end
  end

  always_comb begin
    unlev_now = level_unleveled || dec_bad;
    sum_now   = !pll_locked[rl_sel_pkg::SUM_LOOP] || slew_excess;
    st_set    = {unlev_now, sum_now, ~pll_locked};
    next_mask = mask;
    if (wr_go && addr == rl_sel_pkg::OFF_MASK) begin
      next_mask = hwdata[rl_sel_pkg::ST_W-1:0];
    end
    next_status = status;
    if (rd_go && addr == rl_sel_pkg::OFF_STATUS) begin
      next_status = '0;
    end
    // a set in the clearing cycle survives the read
    next_status = next_status | st_set;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      irq    <= |(next_status & next_mask);
    end
  end

  always_comb begin
    f32  = 32'(freq_reg1);
    step = rl_sel_pkg::TUNE_STEP_KHZ[rl_sel_pkg::NUM_RES-1];
    if (int'(tune_res) < rl_sel_pkg::NUM_RES) begin
      step = rl_sel_pkg::TUNE_STEP_KHZ[tune_res];
    end
    next_freq = freq_reg1;
    next_load = 1'b0;
    if (remote_mode) begin
      if (wr_go && addr == rl_sel_pkg::OFF_FREQ) begin
        next_freq = hwdata[FREQ_W-1:0];
        next_load = 1'b1;
      end
    end else if (enc_step) begin
      next_load = 1'b1;
      // saturate at the band edges rather than wrap round
      if (enc_dir) begin
        if (f32 + step > rl_sel_pkg::FREQ_MAX_KHZ) begin
          next_freq = FREQ_W'(rl_sel_pkg::FREQ_MAX_KHZ);
        end else begin
          next_freq = FREQ_W'(f32 + step);
        end
      end else begin
        if (f32 < rl_sel_pkg::FREQ_MIN_KHZ + step) begin
          next_freq = FREQ_W'(rl_sel_pkg::FREQ_MIN_KHZ);
        end else begin
          next_freq = FREQ_W'(f32 - step);
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      freq_reg1 <= FREQ_W'(rl_sel_pkg::FREQ_MIN_KHZ);
      freq_load <= 1'b0;
    end else begin
      freq_reg1 <= next_freq;
      freq_load <= next_load;
    end
  end

  // assertions sleep one extra cycle so reset values are not judged as live outputs
  logic rst_d;
  always_ff @(posedge sys_clk) begin
    rst_d <= sys_rst;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || rst_d);

  a_local_follow: assert property (
    !remote_mode |=> rf_on_led == $past(panel_rf_on) && fm_led == $past(panel_fm))
    else $error("local indicators do not follow the panel");

  a_remote_hold: assert property (
    remote_mode && !(wr_go && addr == rl_sel_pkg::OFF_SET) |=> $stable(remote_set))
    else $error("remote settings changed without programming");

  a_entry_capture: assert property (
    $rose(remote_mode) |-> remote_set == $past(live_set))
    else $error("panel settings not captured on entering remote");

  a_range_encode: assert property (
    panel_range_pos == 4'h7 |-> local_code == 5'h05)
    else $error("range selector encoded wrongly");

  a_range_show: assert property (
    ##1 range_disp_tens == $past(active_set[3:0]))
    else $error("range display does not match active range");

  a_bad_range: assert property (
    active_set[rl_sel_pkg::F_RANGE +: 5] == rl_sel_pkg::RANGE_BAD |=> unleveled_indicator)
    else $error("illegal range did not light unleveled");

  a_unlev_clear: assert property (
    !level_unleveled && !dec_bad |=> !unleveled_indicator)
    else $error("unleveled lit without cause");

  a_remote_load: assert property (
    remote_mode && wr_go && addr == rl_sel_pkg::OFF_FREQ
    |=> freq_reg1 == $past(hwdata[FREQ_W-1:0]) && freq_load)
    else $error("remote frequency not loaded");

  a_tune_up: assert property (
    !remote_mode && enc_step && enc_dir && tune_res == 3'h3
    && f32 + 32'd1000 <= rl_sel_pkg::FREQ_MAX_KHZ
    |=> freq_reg1 == $past(freq_reg1) + FREQ_W'(1000))
    else $error("encoder step up wrong");

  a_tune_idle: assert property (
    !enc_step && !wr_go |=> $stable(freq_reg1) && !freq_load)
    else $error("frequency moved without cause");

  a_lock_lamps: assert property (
    pll_locked != 4'hF |=> loop_unlock == ~$past(pll_locked))
    else $error("lock lamps wrong");

  a_sum_reset: assert property (
    slew_excess || !pll_locked[rl_sel_pkg::SUM_LOOP] |=> sum_loop_reset)
    else $error("summing loop not reset");

  a_release_local: assert property (
    $fell(remote_mode) |=> rf_on_led == $past(panel_rf_on))
    else $error("panel not followed after leaving remote");

  c_enter_remote: cover property ($rose(remote_mode));
  c_remote_freq:  cover property (remote_mode && wr_go && addr == rl_sel_pkg::OFF_FREQ);
  c_enc_down:     cover property (!remote_mode && enc_step && !enc_dir);
  c_irq:          cover property ($rose(irq));
endmodule : remote_local_input_selector
`default_nettype wire

//--- verification/panel_model.sv
// front panel operator and loop status model driving the selector's panel side
`timescale 1ns/100ps
`default_nettype none
module panel_model (
  input  wire logic       sys_clk,         // system clock
  output logic      [3:0] panel_range_pos, // range selector
  output logic            panel_rf_on,     // rf switch
  output logic      [1:0] panel_alc,       // alc selector
  output logic      [1:0] panel_am,        // am switch
  output logic      [2:0] panel_fm,        // fm switch
  output logic            enc_step,        // detent pulse
  output logic            enc_dir,         // 1 up
  output logic      [2:0] tune_res,        // resolution
  output logic            level_unleveled, // level sense
  output logic      [3:0] pll_locked,      // loop locks
  output logic            slew_excess      // slewing
);
  initial begin
    {panel_range_pos, panel_rf_on, panel_alc, panel_am, panel_fm} = '0;
    {enc_step, enc_dir, tune_res, level_unleveled, slew_excess} = '0;
    pll_locked = 4'hF;
  end
  task automatic set_panel(input logic [3:0] p, input logic r, input logic [1:0] a,
                           input logic [1:0] m, input logic [2:0] f);
    @(posedge sys_clk);
    {panel_range_pos, panel_rf_on, panel_alc, panel_am, panel_fm} <= {p, r, a, m, f};
  endtask : set_panel
  // direction and resolution settle with the pulse, as a real knob would
  task automatic turn(input logic [2:0] r, input logic d);
    @(posedge sys_clk);
    {tune_res, enc_dir, enc_step} <= {r, d, 1'b1};
    @(posedge sys_clk);
    enc_step <= 1'b0;
  endtask : turn
  task automatic set_loops(input logic [3:0] l, input logic s, input logic u);
    @(posedge sys_clk);
    {pll_locked, slew_excess, level_unleveled} <= {l, s, u};
  endtask : set_loops
endmodule : panel_model
`default_nettype wire

//--- verification/remote_local_input_selector_bench.sv
// self-checking bench for the remote/local input selector
`timescale 1ns/100ps
`default_nettype none
module remote_local_input_selector_bench;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic [24:0] freq_reg1;
  logic [4:0]  range_code, exp_code;
  logic [3:0]  range_disp_tens, loop_unlock, panel_range_pos, pll_locked;
  logic [2:0]  fm_led, panel_fm, tune_res;
  logic [1:0]  alc_led, am_led, panel_alc, panel_am;
  logic        hreadyout, hresp, range_disp_ovr, rf_on_led, unleveled_indicator;
  logic        sum_loop_reset, freq_load, remote_led, irq, panel_rf_on;
  logic        enc_step, enc_dir, level_unleveled, slew_excess;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  wire         hready = hreadyout;

  always #50 sys_clk = ~sys_clk;

  panel_model pm (.sys_clk(sys_clk), .panel_range_pos(panel_range_pos),
    .panel_rf_on(panel_rf_on), .panel_alc(panel_alc), .panel_am(panel_am),
    .panel_fm(panel_fm), .enc_step(enc_step), .enc_dir(enc_dir), .tune_res(tune_res),
    .level_unleveled(level_unleveled), .pll_locked(pll_locked), .slew_excess(slew_excess));

  remote_local_input_selector dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .panel_range_pos(panel_range_pos), .panel_rf_on(panel_rf_on), .panel_alc(panel_alc),
    .panel_am(panel_am), .panel_fm(panel_fm), .enc_step(enc_step), .enc_dir(enc_dir),
    .tune_res(tune_res), .level_unleveled(level_unleveled), .pll_locked(pll_locked),
    .slew_excess(slew_excess), .range_code(range_code), .range_disp_tens(range_disp_tens),
    .range_disp_ovr(range_disp_ovr), .rf_on_led(rf_on_led), .alc_led(alc_led),
    .am_led(am_led), .fm_led(fm_led), .unleveled_indicator(unleveled_indicator),
    .loop_unlock(loop_unlock), .sum_loop_reset(sum_loop_reset), .freq_reg1(freq_reg1),
    .freq_load(freq_load), .remote_led(remote_led), .irq(irq));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // run is under two hundred cycles; anything near this ceiling is a hang
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // step past the edge so registered outputs have landed before sampling
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, 1'b1, 2'h2, 24'h0, a};
    @(posedge sys_clk iff hready);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    @(posedge sys_clk iff hready);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, 1'b0, 2'h2, 24'h0, a};
    @(posedge sys_clk iff hready);
    {hsel, htrans} <= {1'b0, 2'h0};
    @(posedge sys_clk iff hready);
    d = hrdata;
  endtask : bus_read

  task automatic step_chk(input logic [2:0] r, input logic d, input logic l,
                          input logic [24:0] e);
    pm.turn(r, d);
    #1;
    chk(freq_load, l);
    idle(1);
    chk(freq_reg1, e);
    chk(freq_load, 1'b0);
  endtask : step_chk

  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int p = 1; p <= 13; p++) begin
      pm.set_panel(4'(p), 1'b1, 2'h1, 2'h2, 3'h5);
      idle(3);
      exp_code = (p == 13) ? 5'h10 : 5'(12 - p);
      chk(range_code, exp_code);
      chk({range_disp_ovr, range_disp_tens}, exp_code);
      chk(unleveled_indicator, 1'b0);
    end
    chk({fm_led, am_led, alc_led, rf_on_led}, {3'h5, 2'h2, 2'h1, 1'b1});
    pm.set_panel(4'h0, 1'b1, 2'h1, 2'h2, 3'h5);
    idle(3);
    chk(range_code, 5'h0F);
    chk(unleveled_indicator, 1'b1);
    pm.set_panel(4'h7, 1'b1, 2'h2, 2'h1, 3'h3);
    step_chk(3'h3, 1'b1, 1'b1, 25'd2001000);
    step_chk(3'h0, 1'b0, 1'b1, 25'd2000999);
    step_chk(3'h5, 1'b0, 1'b1, 25'd2000000);
    step_chk(3'h7, 1'b1, 1'b1, 25'd2100000);
    bus_write(8'h00, 32'h1);
    pm.set_panel(4'h2, 1'b0, 2'h0, 2'h0, 3'h0);
    idle(3);
    chk(remote_led, 1'b1);
    chk({fm_led, am_led, alc_led, rf_on_led, range_code}, 13'h0DA5);
    bus_write(8'h04, {19'h0, 3'h6, 2'h2, 2'h1, 1'b1, 5'h03});
    pm.set_panel(4'hD, 1'b1, 2'h3, 2'h3, 3'h7);
    idle(3);
    chk({fm_led, am_led, alc_led, rf_on_led, range_code}, 13'h1A63);
    bus_write(8'h04, 32'h1C);
    idle(2);
    chk(unleveled_indicator, 1'b1);
    bus_read(8'h04, rd);
    chk(rd, 32'h1C);
    bus_write(8'h08, 32'd5000000);
    idle(1);
    chk(freq_reg1, 25'd5000000);
    bus_read(8'h08, rd);
    chk(rd, 32'd5000000);
    step_chk(3'h3, 1'b1, 1'b0, 25'd5000000);
    bus_write(8'h00, 32'h0);
    idle(2);
    chk(remote_led, 1'b0);
    chk({fm_led, am_led, alc_led, rf_on_led, range_code}, 13'h1FF0);
    chk(unleveled_indicator, 1'b0);
    bus_write(8'h08, 32'd7000000);
    idle(1);
    chk(freq_reg1, 25'd5000000);
    pm.set_loops(4'h6, 1'b0, 1'b1);
    idle(3);
    chk(loop_unlock, 4'h9);
    chk(sum_loop_reset, 1'b1);
    chk(unleveled_indicator, 1'b1);
    chk(irq, 1'b0);
    bus_write(8'h10, 32'h01);
    idle(1);
    chk(irq, 1'b1);
    pm.set_loops(4'hF, 1'b1, 1'b0);
    idle(3);
    chk(loop_unlock, 4'h0);
    chk(sum_loop_reset, 1'b1);
    pm.set_loops(4'hF, 1'b0, 1'b0);
    idle(3);
    chk(sum_loop_reset, 1'b0);
    bus_read(8'h0C, rd);
    chk(rd, 32'h39);
    bus_read(8'h0C, rd);
    chk(rd, 32'h0);
    idle(1);
    chk(irq, 1'b0);
    bus_read(8'h10, rd);
    chk(rd, 32'h01);
    bus_read(8'h14, rd);
    chk(rd, 32'h0001_FF0F);
    bus_read(8'h00, rd);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    bus_read(8'h18, rd);
    chk(rd, 32'h0);
    give_verdict();
  end
endmodule : remote_local_input_selector_bench
`default_nettype wire
